// ### rtl/bsc_pkg.sv
// Constants, types and register map for the buck status and config register bank.
// Assumes a 100 MHz system clock; the fault and power-good inputs are analog comparator levels.
package bsc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] CFG_OFFSET = 8'h05;
  localparam logic [7:0] WDG_OFFSET = 8'h42;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] CFG_RESET = 8'hA4;
  localparam logic [7:0] WDG_RESET = 8'h00;
  localparam int OT_BIT = 1;
  localparam int UV_BIT = 0;
  localparam int WDG_BIT = 1;
  localparam int CFG_LSB = 2;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // Bus address of this device; value is arbitrary
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2A;

  // ----------------------------------------------------------------
  // Input synchroniser slots
  // ----------------------------------------------------------------
  localparam int IN_NUM = 5;
  localparam int IN_SCL = 4;
  localparam int IN_SDA = 3;
  localparam int IN_OT = 2;
  localparam int IN_UV = 1;
  localparam int IN_PG = 0;
  localparam logic [IN_NUM-1:0] IN_IDLE = 5'h18;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int PG_STEP_US = 10;
  localparam logic [11:0] PG_CYC_0 = 12'h000;
  localparam logic [11:0] PG_CYC_10 = 12'(PG_STEP_US * CLK_MHZ);
  localparam logic [11:0] PG_CYC_20 = 12'(2 * PG_STEP_US * CLK_MHZ);
  localparam logic [11:0] PG_CYC_40 = 12'(4 * PG_STEP_US * CLK_MHZ);
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] LAST_BIT = 4'h7;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] current_limit_select;
    logic [1:0] thermal_trip_select;
    logic [1:0] power_good_delay_select;
  } bsc_prot_cfg_t;

  localparam bsc_prot_cfg_t CFG_FIELDS_RESET = CFG_RESET[7:CFG_LSB];

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR = 4'h1,
    ST_REG = 4'h2,
    ST_WDATA = 4'h3,
    ST_ACK_REG = 4'h4,
    ST_ACK_WR = 4'h5,
    ST_ACK_RD = 4'h6,
    ST_RDATA = 4'h7,
    ST_RACK = 4'h8
  } bsc_state_t;

endpackage : bsc_pkg

// ### rtl/bsc_regs.sv
// Two-wire bus slave with the fault status, protection settings and watchdog registers.
// Assumes SCL/SDA and the analog flags are asynchronous; SDA is open drain outside.
//
// How it works
// R01: The status register at 0x04 is read only, resets to zero, and bits 7:2 read zero.
// R02: Status bit 1 reads one exactly while over-temperature is present.
// R03: Status bit 0 reads one exactly while output under-voltage is present.
// R04: The settings register at 0x05 holds the three fields, resets to 0xA4, bits 1:0 read zero.
// R05: Bits 7:6 pick the current limit: off, 8A, 8.8A (default) or 9.6A.
// R06: Bits 5:4 pick the thermal trip: off, 140C, 150C (default) or 170C.
// R07: Bits 3:2 set the power-good enable wait: 0, 10 (default), 20 or 40 us.
// R08: Register 0x42 has one writable bit 1 that enables the watchdog reset, reset zero.
// R09: Status flags are live, and reading the status register changes nothing.
`timescale 1ns/1ps

module bsc_regs #(
  parameter logic [6:0] DEV_ADDR = bsc_pkg::DEV_ADDR_DEFAULT
) (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n_out,
  input wire logic over_temp_in,
  input wire logic under_voltage_in,
  input wire logic power_good_in,
  output bsc_pkg::bsc_prot_cfg_t prot_cfg_out,
  output logic watchdog_reset_enable_out,
  output logic power_good_output_out
);
  import bsc_pkg::*;

  // ----------------------------------------------------------------
  // Synchronisers and bus edge detection
  // ----------------------------------------------------------------
  logic [IN_NUM-1:0] sync1_reg;
  logic [IN_NUM-1:0] sync2_reg;
  logic scl_d_reg;
  logic sda_d_reg;
  // SDA only ever pulls low; level flop keeps the output registered
  logic sda_lvl_reg;

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sync1_reg <= IN_IDLE;
      sync2_reg <= IN_IDLE;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      sda_lvl_reg <= 1'b0;
    end else begin
      sync1_reg <= {scl_in, sda_in, over_temp_in, under_voltage_in, power_good_in};
      sync2_reg <= sync1_reg;
      scl_d_reg <= sync2_reg[IN_SCL];
      sda_d_reg <= sync2_reg[IN_SDA];
      sda_lvl_reg <= 1'b0;
    end
  end

  wire logic scl_s = sync2_reg[IN_SCL];
  wire logic sda_s = sync2_reg[IN_SDA];
  wire logic bus_start = scl_s && scl_d_reg && sda_d_reg && !sda_s;
  wire logic bus_stop = scl_s && scl_d_reg && !sda_d_reg && sda_s;
  wire logic scl_rise = scl_s && !scl_d_reg;
  wire logic scl_fall = !scl_s && scl_d_reg;

  // ----------------------------------------------------------------
  // Bus state machine and registers
  // ----------------------------------------------------------------
  bsc_state_t st_reg, st_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [7:0] sh_reg, sh_next;
  logic [7:0] ptr_reg, ptr_next;
  logic sda_oe_n_reg, sda_oe_n_next;
  logic [7:0] status_reg, status_next;
  bsc_prot_cfg_t cfg_reg, cfg_next;
  logic wdg_reg, wdg_next;
  logic wr_en;
  logic [7:0] rd_data;
  wire logic [2:0] bit_idx = 3'(LAST_BIT - cnt_reg);

  always_comb begin
    unique case (ptr_reg)
      STATUS_OFFSET: rd_data = status_reg;
      CFG_OFFSET: rd_data = {cfg_reg, 2'h0}; // see R04
      WDG_OFFSET: rd_data = {6'h00, wdg_reg, 1'h0}; // see R08
      default: rd_data = BYTE_ZERO;
    endcase
  end

  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    sh_next = sh_reg;
    ptr_next = ptr_reg;
    sda_oe_n_next = sda_oe_n_reg;
    cfg_next = cfg_reg;
    wdg_next = wdg_reg;
    wr_en = 1'b0;
    // Live copy, no latching; reads never touch it
    status_next = STATUS_RESET;
    status_next[OT_BIT] = sync2_reg[IN_OT]; // see R02, R09
    status_next[UV_BIT] = sync2_reg[IN_UV]; // see R03, R09
    if (bus_start) begin
      st_next = ST_ADDR;
      cnt_next = 4'h0;
      sda_oe_n_next = 1'b1;
    end else if (bus_stop) begin
      st_next = ST_IDLE;
      sda_oe_n_next = 1'b1;
    end else if (scl_rise) begin
      unique case (st_reg)
        ST_ADDR, ST_REG, ST_WDATA: begin
          sh_next = {sh_reg[6:0], sda_s};
          cnt_next = cnt_reg + 4'h1;
        end
        ST_RDATA: cnt_next = cnt_reg + 4'h1;
        // Master NACK ends the read; wait for stop
        ST_RACK: if (sda_s) st_next = ST_IDLE;
        default: ;
      endcase
    end else if (scl_fall) begin
      unique case (st_reg)
        ST_ADDR: begin
          if (cnt_reg == BITS_PER_BYTE) begin
            if (sh_reg[7:1] == DEV_ADDR) begin
              sda_oe_n_next = 1'b0;
              st_next = sh_reg[0] ? ST_ACK_RD : ST_ACK_REG;
            end else begin
              st_next = ST_IDLE;
            end
          end
        end
        ST_REG: begin
          if (cnt_reg == BITS_PER_BYTE) begin
            ptr_next = sh_reg;
            sda_oe_n_next = 1'b0;
            st_next = ST_ACK_WR;
          end
        end
        ST_WDATA: begin
          if (cnt_reg == BITS_PER_BYTE) begin
            wr_en = 1'b1;
            ptr_next = ptr_reg + 8'h01;
            sda_oe_n_next = 1'b0;
            st_next = ST_ACK_WR;
          end
        end
        ST_ACK_REG, ST_ACK_WR: begin
          sda_oe_n_next = 1'b1;
          cnt_next = 4'h0;
          st_next = (st_reg == ST_ACK_REG) ? ST_REG : ST_WDATA;
        end
        ST_ACK_RD, ST_RACK: begin
          sh_next = rd_data;
          sda_oe_n_next = rd_data[7];
          ptr_next = ptr_reg + 8'h01;
          cnt_next = 4'h0;
          st_next = ST_RDATA;
        end
        ST_RDATA: begin
          if (cnt_reg == BITS_PER_BYTE) begin
            sda_oe_n_next = 1'b1;
            st_next = ST_RACK;
          end else begin
            sda_oe_n_next = sh_reg[bit_idx];
          end
        end
        default: st_next = ST_IDLE;
      endcase
    end
    // Status stays read only: writes to it are dropped
    if (wr_en && ptr_reg == CFG_OFFSET) begin
      cfg_next = sh_reg[7:CFG_LSB]; // see R04, R05, R06, R07
    end
    if (wr_en && ptr_reg == WDG_OFFSET) begin
      wdg_next = sh_reg[WDG_BIT]; // see R08
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_reg <= ST_IDLE;
      cnt_reg <= 4'h0;
      sh_reg <= BYTE_ZERO;
      ptr_reg <= BYTE_ZERO;
      sda_oe_n_reg <= 1'b1;
      status_reg <= STATUS_RESET; // see R01
      cfg_reg <= CFG_FIELDS_RESET; // see R04
      wdg_reg <= WDG_RESET[WDG_BIT]; // see R08
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      sh_reg <= sh_next;
      ptr_reg <= ptr_next;
      sda_oe_n_reg <= sda_oe_n_next;
      status_reg <= status_next;
      cfg_reg <= cfg_next;
      wdg_reg <= wdg_next;
    end
  end

  // ----------------------------------------------------------------
  // Power-good enable delay
  // ----------------------------------------------------------------
  logic [11:0] pg_cnt_reg, pg_cnt_next;
  logic pg_out_reg, pg_out_next;
  logic [11:0] pg_limit;

  always_comb begin
    unique case (cfg_reg.power_good_delay_select) // see R07
      2'h0: pg_limit = PG_CYC_0;
      2'h1: pg_limit = PG_CYC_10;
      2'h2: pg_limit = PG_CYC_20;
      2'h3: pg_limit = PG_CYC_40;
    endcase
  end

  always_comb begin
    pg_cnt_next = pg_cnt_reg;
    pg_out_next = pg_out_reg;
    if (!sync2_reg[IN_PG]) begin
      pg_cnt_next = PG_CYC_0;
      pg_out_next = 1'b0;
    end else if (pg_cnt_reg >= pg_limit) begin
      pg_out_next = 1'b1; // see R07
    end else begin
      pg_cnt_next = pg_cnt_reg + 12'h001;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pg_cnt_reg <= PG_CYC_0;
      pg_out_reg <= 1'b0;
    end else begin
      pg_cnt_reg <= pg_cnt_next;
      pg_out_reg <= pg_out_next;
    end
  end

  assign sda_out = sda_lvl_reg;
  assign sda_oe_n_out = sda_oe_n_reg;
  assign prot_cfg_out = cfg_reg;
  assign watchdog_reset_enable_out = wdg_reg;
  assign power_good_output_out = pg_out_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic [1:0] live_reg;
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      live_reg <= 2'h0;
    end else if (live_reg != 2'h3) begin
      live_reg <= live_reg + 2'h1;
    end
  end

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);
  sequence s_cfg_write;
    wr_en && ptr_reg == CFG_OFFSET;
  endsequence
  sequence s_wdg_write;
    wr_en && ptr_reg == WDG_OFFSET;
  endsequence
  a_status_resv_zero: assert property (status_reg[7:2] == 6'h00) // see R01
    else $error("status reserved bits not zero");
  a_ot_tracks_pin: assert property ( // see R02
    live_reg == 2'h3 |-> status_reg[OT_BIT] == $past(over_temp_in, 3))
    else $error("over-temp flag does not follow input");
  a_uv_tracks_pin: assert property ( // see R03
    live_reg == 2'h3 |-> status_reg[UV_BIT] == $past(under_voltage_in, 3))
    else $error("under-voltage flag does not follow input");
  a_cfg_low_zero: assert property ( // see R04
    ptr_reg == CFG_OFFSET |-> rd_data[1:0] == 2'h0 && rd_data[7:CFG_LSB] == cfg_reg)
    else $error("settings readback wrong");
  a_limit_write: assert property ( // see R05
    s_cfg_write |=> prot_cfg_out.current_limit_select == $past(sh_reg[7:6]))
    else $error("current limit field not written");
  a_trip_write: assert property ( // see R06
    s_cfg_write |=> prot_cfg_out.thermal_trip_select == $past(sh_reg[5:4]))
    else $error("thermal trip field not written");
  a_pg_delay_wait: assert property ( // see R07
    $rose(power_good_output_out) |-> $past(pg_cnt_reg) >= $past(pg_limit)
      && $past(sync2_reg[IN_PG]))
    else $error("power-good enabled before delay");
  a_wdg_write: assert property ( // see R08
    s_wdg_write |-> (rd_data[7:2] == 6'h00 && !rd_data[0])
      ##1 (watchdog_reset_enable_out == $past(sh_reg[WDG_BIT])))
    else $error("watchdog enable write wrong");
  a_status_read_keep: assert property ( // see R09
    live_reg == 2'h3 && st_reg == ST_RDATA && $stable(sync2_reg[IN_OT])
      && $stable(sync2_reg[IN_UV]) |=> $stable(status_reg))
    else $error("status changed by a read");

endmodule : bsc_regs

// ### tb/bsc_host.sv
// Behavioural two-wire bus master that drives the register bank.
// Assumes the bench resolves SDA as a pulled-up wire of both drivers.
`timescale 1ns/1ps

module bsc_host (
  input wire logic clk_sys_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_out
);
  import bsc_pkg::*;

  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end

  // Eight cycles a phase; the slave's input sync eats three
  task automatic half();
    repeat (8) @(posedge clk_sys_in);
    #1;
  endtask : half

  task automatic start();
    sda_out = 1'b1;
    half();
    scl_out = 1'b1;
    half();
    sda_out = 1'b0;
    half();
    scl_out = 1'b0;
  endtask : start

  task automatic stop();
    sda_out = 1'b0;
    half();
    scl_out = 1'b1;
    half();
    sda_out = 1'b1;
    half();
  endtask : stop

  // MSB first, ninth bit driven with nb and sampled back
  task automatic xfer(input logic [7:0] d, input logic nb, output logic [7:0] q,
                      output logic ninth);
    logic [8:0] sh;
    sh = {d, nb};
    for (int i = 8; i >= 0; i--) begin
      repeat (3) @(posedge clk_sys_in);
      #1;
      sda_out = sh[i];
      half();
      scl_out = 1'b1;
      half();
      sh[i] = sda_in;
      scl_out = 1'b0;
    end
    q = sh[8:1];
    ninth = sh[0];
  endtask : xfer

  task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d,
                    output logic acked);
    logic [7:0] q;
    logic n0, n1, n2;
    start();
    xfer({a, 1'b0}, 1'b1, q, n0);
    xfer(p, 1'b1, q, n1);
    xfer(d, 1'b1, q, n2);
    stop();
    acked = !(n0 | n1 | n2);
  endtask : wr

  // Pointer write, repeated start, one byte, then NACK
  task automatic rd(input logic [7:0] p, output logic [7:0] d);
    logic [7:0] q;
    logic n;
    start();
    xfer({DEV_ADDR_DEFAULT, 1'b0}, 1'b1, q, n);
    xfer(p, 1'b1, q, n);
    start();
    xfer({DEV_ADDR_DEFAULT, 1'b1}, 1'b1, q, n);
    xfer(8'hFF, 1'b1, d, n);
    stop();
  endtask : rd
endmodule : bsc_host

// ### tb/bsc_regs_tb.sv
// Self-checking bench for the buck status and settings register bank.
// Assumes the host model in bsc_host.sv and a pull-up on SDA.
`timescale 1ns/1ps

module bsc_regs_tb;
  import bsc_pkg::*;
  logic clk_sys_in = 1'b0;
  logic rstn_in = 1'b0;
  logic ot = 1'b0;
  logic uv = 1'b0;
  logic pg = 1'b0;
  logic scl, host_sda, sda_drv, sda_oe_n, wdg, pg_out, ack;
  logic [7:0] rv, v;
  logic [7:0] corner [4] = '{8'h00, 8'h57, 8'hAB, 8'hFE};
  bsc_prot_cfg_t cfg;
  int mismatches = 0;
  int tests_run = 0;
  int n;
  wire logic sda_wire = host_sda & (sda_oe_n | sda_drv);

  always #5 clk_sys_in = ~clk_sys_in;

  bsc_regs dut (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .scl_in(scl),
    .sda_in(sda_wire), .sda_out(sda_drv), .sda_oe_n_out(sda_oe_n), .over_temp_in(ot),
    .under_voltage_in(uv), .power_good_in(pg), .prot_cfg_out(cfg),
    .watchdog_reset_enable_out(wdg), .power_good_output_out(pg_out));

  bsc_host host (.clk_sys_in(clk_sys_in), .sda_in(sda_wire), .scl_out(scl),
    .sda_out(host_sda));

  // ----------------------------------------------------------------
  // Checking helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic rdchk(input logic [7:0] p, input logic [7:0] exp);
    host.rd(p, rv);
    chk(rv, exp);
  endtask : rdchk

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : print_verdict

  function automatic int pg_cyc(input int s);
    return (s == 0) ? int'(PG_CYC_0) : (s == 1) ? int'(PG_CYC_10) :
           (s == 2) ? int'(PG_CYC_20) : int'(PG_CYC_40);
  endfunction : pg_cyc

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(93));
    repeat (4) @(posedge clk_sys_in);
    #1;
    rstn_in = 1'b1;
    rdchk(STATUS_OFFSET, STATUS_RESET);
    rdchk(CFG_OFFSET, CFG_RESET);
    rdchk(WDG_OFFSET, WDG_RESET);
    chk({2'b00, cfg}, {2'b00, CFG_FIELDS_RESET});
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      {ot, uv} = (i < 4) ? 2'(i) : 2'($urandom);
      rdchk(STATUS_OFFSET, {6'h00, ot, uv});
      rdchk(STATUS_OFFSET, {6'h00, ot, uv});
    end
    {ot, uv} = 2'b00;
    $display("test status done");
    for (int i = 0; i < 8; i++) begin
      v = (i < 4) ? corner[i] : 8'($urandom);
      host.wr(DEV_ADDR_DEFAULT, CFG_OFFSET, v, ack);
      chk({7'h00, ack}, 8'h01);
      chk({2'b00, cfg}, {2'b00, v[7:2]});
      rdchk(CFG_OFFSET, {v[7:2], 2'b00});
    end
    // Status is read only; a wrong address must leave settings alone
    host.wr(DEV_ADDR_DEFAULT, STATUS_OFFSET, 8'hFF, ack);
    rdchk(STATUS_OFFSET, 8'h00);
    host.wr(DEV_ADDR_DEFAULT ^ 7'h01, CFG_OFFSET, ~v, ack);
    chk({7'h00, ack}, 8'h00);
    chk({2'b00, cfg}, {2'b00, v[7:2]});
    $display("test settings done");
    for (int i = 0; i < 2; i++) begin
      v = (i == 0) ? 8'hFF : 8'h00;
      host.wr(DEV_ADDR_DEFAULT, WDG_OFFSET, v, ack);
      chk({7'h00, wdg}, {7'h00, v[WDG_BIT]});
      rdchk(WDG_OFFSET, {6'h00, v[WDG_BIT], 1'b0});
    end
    $display("test watchdog done");
    for (int s = 0; s < 4; s++) begin
      host.wr(DEV_ADDR_DEFAULT, CFG_OFFSET, {4'hA, 2'(s), 2'b00}, ack);
      pg = 1'b1;
      n = 0;
      while (pg_out !== 1'b1 && n < 5000) begin
        @(posedge clk_sys_in);
        #1;
        n++;
      end
      chk({7'h00, n >= pg_cyc(s) && n <= pg_cyc(s) + 4}, 8'h01);
      pg = 1'b0;
      repeat (6) @(posedge clk_sys_in);
      #1;
      chk({7'h00, pg_out}, 8'h00);
    end
    $display("test power good done");
    print_verdict();
  end

  // Whole run is near 36k cycles; give it 100k
  initial begin
    #1ms;
    mismatches++;
    $display("mismatch at %0t: watchdog expired", $time);
    print_verdict();
  end
endmodule : bsc_regs_tb
